// *** rtl/chip_reset_and_strap_control.sv ***
// chip level reset sequencer with register port and strap latch
//
// Behaviour
// - power-up holds the internal reset about 22 ms by an internal timer
// - finishing power-on reset starts a full EEPROM load
// - power-on, pin, soft and USB resets put the Ethernet PHY in power-down
// - low external reset pin resets chip; ready reads 0 until done, then 1
// - reset pin pulled high inside; unused pin means host issues soft reset
// - lite reset spares USB core, USB PHY/HSIC, part of control; PLL runs
// - lite reset reloads no USB EEPROM data and keeps USB configured
// - writing bit 0 of hw config starts soft reset; bit clears after 2 us
// - soft reset keeps the preserved control bits
// - soft reset reloads the EEPROM
// - soft reset still acks first good OUT data, then disconnects from USB
// - USB reset spares USB core and HSIC, PLL runs; follows POR, pin, soft
// - after USB reset ready reads 0 until EEPROM load ends, then 1
// - USB reset reloads only the MAC address from EEPROM
// - active-low test reset resets only the TAP controller
// - straps float in POR or pin reset, latched at release, driven otherwise
// - straps latch only on power-on or pin reset
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module chip_reset_and_strap_control
  import rst_pkg::*;
#(
  parameter int unsigned POR_CNT = POR_CYCLES
)(
  // clock, reset, enable
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  // external pins
  input wire logic i_external_reset_n,
  input wire logic i_test_reset_n,
  // register port
  input wire logic [ADDR_W-1:0] i_reg_addr,
  input wire logic [DATA_W-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [DATA_W-1:0] o_reg_rdata,
  // usb device core
  input wire logic i_usb_bus_reset,
  input wire logic i_out_data_ack,
  output logic o_usb_disconnect,
  // eeprom loader
  input wire logic i_eeprom_present,
  input wire logic i_eeprom_done,
  output logic o_eeprom_full_load,
  output logic o_eeprom_mac_load,
  // internal resets and power
  output logic o_core_rst,
  output logic o_usb_core_rst,
  output logic o_tap_rst,
  output logic o_pll_enable,
  output logic o_phy_power_down,
  // configuration strap pins
  input wire logic [STRAP_W-1:0] i_strap_pin,
  output logic [STRAP_W-1:0] o_strap_pin,
  output logic o_strap_oe_n,
  output logic [STRAP_W-1:0] o_strap_value
);

  localparam logic [CNT_W-1:0] POR_LOAD = CNT_W'(POR_CNT - 1);
  localparam logic [CNT_W-1:0] SOFT_LOAD = CNT_W'(SOFT_CYCLES - 1);
  localparam logic [CNT_W-1:0] USB_LOAD = CNT_W'(USB_RST_CYCLES - 1);
  localparam logic [CNT_W-1:0] LITE_LOAD = CNT_W'(LITE_CYCLES - 1);

  state_t state_q;
  state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic full_q;
  logic full_d;
  logic load_go;
  logic [HW_GEN_W-1:0] gen_q;
  logic [HW_KEEP_W-1:0] keep_q;
  logic phy_pd_q;
  logic ready_q;
  logic [STRAP_W-1:0] strap_out_q;
  logic [DATA_W-1:0] rdata_q;
  logic full_load_q;
  logic mac_load_q;
  logic disc_q;
  logic pll_q;
  logic oe_n_q;
  logic tap_q;

  rst_req_if rq ();

  // register decode
  wire hw_sel = (i_reg_addr == HW_CONFIG_OFS);
  wire pmt_sel = (i_reg_addr == PMT_OFS);
  wire strap_sel = (i_reg_addr == STRAP_OUT_OFS);
  wire hw_wr = i_reg_wr && hw_sel;
  wire pmt_wr = i_reg_wr && pmt_sel;
  wire strap_wr = i_reg_wr && strap_sel;
  wire soft_wr = hw_wr && i_reg_wdata[HW_SOFT_BIT];
  wire lite_wr = hw_wr && i_reg_wdata[HW_LITE_BIT];
  wire cnt_done = (cnt_q == '0);

  // state groups
  wire in_hard = (state_q == ST_POR) || (state_q == ST_PIN);
  wire in_soft = (state_q == ST_SOFT_WAIT) || (state_q == ST_SOFT);
  wire soft_start = (state_q == ST_SOFT_WAIT) && i_out_data_ack && i_external_reset_n;
  wire pd_phase = in_hard || (state_q == ST_SOFT) || (state_q == ST_BUSRST);
  wire hard_next = (state_d == ST_POR) || (state_d == ST_PIN);
  wire strap_capture_go = in_hard && !hard_next;
  wire ready_next = (state_d == ST_RUN) || (state_d == ST_LITE);

  // sequencer: the external pin overrides every other phase
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_done ? cnt_q : cnt_q - 1'b1;
    full_d = full_q;
    load_go = 1'b0;
    if (!i_external_reset_n) begin
      state_d = ST_PIN;
      full_d = 1'b1;
    end else begin
      case (state_q)
        ST_POR: begin
          if (cnt_done) begin
            state_d = ST_BUSRST;
            cnt_d = USB_LOAD;
          end
        end
        ST_PIN: begin
          state_d = ST_BUSRST;
          cnt_d = USB_LOAD;
        end
        ST_RUN: begin
          if (i_usb_bus_reset) begin
            state_d = ST_BUSRST;
            full_d = 1'b0;
            cnt_d = USB_LOAD;
          end else if (soft_wr) begin
            state_d = ST_SOFT_WAIT;
          end else if (lite_wr) begin
            state_d = ST_LITE;
            cnt_d = LITE_LOAD;
          end
        end
        ST_SOFT_WAIT: begin
          if (i_out_data_ack) begin
            state_d = ST_SOFT;
            cnt_d = SOFT_LOAD;
          end
        end
        ST_SOFT: begin
          if (cnt_done) begin
            state_d = ST_BUSRST;
            full_d = 1'b1;
            cnt_d = USB_LOAD;
          end
        end
        ST_BUSRST: begin
          if (cnt_done && !i_usb_bus_reset) begin
            state_d = ST_LOAD;
            load_go = 1'b1;
          end
        end
        ST_LOAD: begin
          if (i_usb_bus_reset) begin
            state_d = ST_BUSRST;
            full_d = 1'b0;
            cnt_d = USB_LOAD;
          end else if (!i_eeprom_present || i_eeprom_done) begin
            state_d = ST_RUN;
          end
        end
        ST_LITE: begin
          // no eeprom load and no usb reset here, so usb state survives
          if (cnt_done) begin
            state_d = ST_RUN;
          end
        end
        default: begin
          state_d = ST_POR;
          cnt_d = POR_LOAD;
        end
      endcase
    end
  end

  // sequencer state; the power-on timer starts from the reset release
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_q <= ST_POR;
      cnt_q <= POR_LOAD;
      full_q <= 1'b1;
    end else if (i_clk_en) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      full_q <= full_d;
    end
  end

  // internal reset requests; usb core is spared by lite and usb resets
  assign rq.req[RST_CORE] = in_hard || (state_q == ST_SOFT) || (state_q == ST_BUSRST)
    || (state_q == ST_LITE);
  assign rq.req[RST_USB] = in_hard || (state_q == ST_SOFT);

  rst_release_sync u_sync (
    .i_clock (i_clock),
    .i_rst (i_rst),
    .i_clk_en (i_clk_en),
    .rq (rq.sync)
  );

  // hw_config_reg: general bits cleared by soft reset, preserved bits are not
  always_ff @(posedge i_clock) begin
    if (i_rst || !i_external_reset_n) begin
      gen_q <= HW_GEN_RST;
      keep_q <= HW_KEEP_RST;
    end else if (i_clk_en) begin
      if (soft_start) begin
        gen_q <= HW_GEN_RST;
      end else if (hw_wr) begin
        gen_q <= i_reg_wdata[HW_GEN_LSB +: HW_GEN_W];
      end
      if (hw_wr) begin
        keep_q <= i_reg_wdata[HW_KEEP_LSB +: HW_KEEP_W];
      end
    end
  end

  // phy power-down: power-on, pin, soft and usb reset phases set it and win over a software clear
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      phy_pd_q <= 1'b1;
    end else if (i_clk_en) begin
      if (pd_phase) begin
        phy_pd_q <= 1'b1;
      end else if (pmt_wr) begin
        phy_pd_q <= i_reg_wdata[PMT_PHY_PD_BIT];
      end
    end
  end

  // readiness and software strap drive value
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ready_q <= 1'b0;
      strap_out_q <= STRAP_RST;
    end else if (i_clk_en) begin
      ready_q <= ready_next;
      if (strap_wr) begin
        strap_out_q <= i_reg_wdata[STRAP_W-1:0];
      end
    end
  end

  // read mux; soft and lite bits read 1 until their reset completes
  wire [DATA_W-1:0] hw_rd = {
    {(DATA_W - HW_KEEP_LSB - HW_KEEP_W){1'b0}}, keep_q, gen_q,
    (state_q == ST_LITE), in_soft
  };
  wire [DATA_W-1:0] pmt_rd = {
    {(DATA_W - PMT_STRAP_LSB - STRAP_W){1'b0}}, o_strap_value,
    {(PMT_STRAP_LSB - 2){1'b0}}, phy_pd_q, ready_q
  };
  wire [DATA_W-1:0] strap_rd = {{(DATA_W - STRAP_W){1'b0}}, strap_out_q};
  wire [DATA_W-1:0] rd_mux = hw_sel ? hw_rd : pmt_sel ? pmt_rd : strap_sel ? strap_rd : '0;

  // read data stand only in the cycle after the strobe
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rdata_q <= '0;
    end else if (i_clk_en) begin
      rdata_q <= i_reg_rd ? rd_mux : '0;
    end
  end

  // eeprom load strobes: full after power-on, pin and soft, mac only otherwise
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      full_load_q <= 1'b0;
      mac_load_q <= 1'b0;
    end else if (i_clk_en) begin
      full_load_q <= load_go && i_eeprom_present && full_q;
      mac_load_q <= load_go && i_eeprom_present && !full_q;
    end
  end

  // usb link, pll and strap pin control
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      disc_q <= 1'b1;
      pll_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else if (i_clk_en) begin
      disc_q <= hard_next || (state_d == ST_SOFT);
      pll_q <= !hard_next;
      oe_n_q <= hard_next;
    end
  end

  // tap reset follows only the test reset pin
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      tap_q <= 1'b1;
    end else if (i_clk_en) begin
      tap_q <= !i_test_reset_n;
    end
  end

  // straps are sampled in the cycle that power-on or pin reset releases
  strap_capture u_strap (
    .i_clock (i_clock),
    .i_rst (i_rst),
    .i_clk_en (i_clk_en),
    .i_capture (strap_capture_go),
    .i_pins (i_strap_pin),
    .o_value (o_strap_value)
  );

  // outputs
  assign o_reg_rdata = rdata_q;
  assign o_usb_disconnect = disc_q;
  assign o_eeprom_full_load = full_load_q;
  assign o_eeprom_mac_load = mac_load_q;
  assign o_core_rst = rq.rst[RST_CORE];
  assign o_usb_core_rst = rq.rst[RST_USB];
  assign o_tap_rst = tap_q;
  assign o_pll_enable = pll_q;
  assign o_phy_power_down = phy_pd_q;
  assign o_strap_pin = strap_out_q;
  assign o_strap_oe_n = oe_n_q;

endmodule : chip_reset_and_strap_control

// *** rtl/rst_pkg.sv ***
// shared constants, register map and state type of the chip reset controller
package rst_pkg;

  // clock and timing
  localparam int unsigned CLOCK_HZ = 50_000_000;
  localparam int unsigned CLOCK_NS = 1_000_000_000 / CLOCK_HZ;
  localparam int unsigned POR_TIME_MS = 22;
  localparam int unsigned POR_CYCLES = POR_TIME_MS * (CLOCK_HZ / 1000);
  localparam int unsigned SOFT_TIME_NS = 2000;
  localparam int unsigned SOFT_CYCLES = SOFT_TIME_NS / CLOCK_NS;
  localparam int unsigned USB_RST_CYCLES = 16;
  localparam int unsigned LITE_CYCLES = 8;
  localparam int unsigned CNT_W = 21;

  // register port
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] HW_CONFIG_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] PMT_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] STRAP_OUT_OFS = 8'h08;

  // hw_config_reg fields
  localparam int unsigned HW_SOFT_BIT = 0;
  localparam int unsigned HW_LITE_BIT = 1;
  localparam int unsigned HW_GEN_LSB = 2;
  localparam int unsigned HW_GEN_W = 6;
  localparam int unsigned HW_KEEP_LSB = 8;
  localparam int unsigned HW_KEEP_W = 8;
  localparam logic [HW_GEN_W-1:0] HW_GEN_RST = 6'h00;
  localparam logic [HW_KEEP_W-1:0] HW_KEEP_RST = 8'h00;

  // power_mgmt_ctrl_reg fields
  localparam int unsigned PMT_READY_BIT = 0;
  localparam int unsigned PMT_PHY_PD_BIT = 1;
  localparam int unsigned PMT_STRAP_LSB = 8;

  // strap pins
  localparam int unsigned STRAP_W = 4;
  localparam logic [STRAP_W-1:0] STRAP_RST = 4'h0;

  // internal reset domains
  localparam int unsigned NRST = 2;
  localparam int unsigned RST_CORE = 0;
  localparam int unsigned RST_USB = 1;

  typedef enum logic [2:0] {
    ST_POR, ST_PIN, ST_RUN, ST_SOFT_WAIT, ST_SOFT, ST_BUSRST, ST_LOAD, ST_LITE
  } state_t;

endpackage : rst_pkg

// *** rtl/rst_release_sync.sv ***
// immediate assertion, clock-aligned release of each internal reset
`timescale 1ns/1ps
module rst_release_sync
  import rst_pkg::*;
(
  // clock and control
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  // requests in, resets out
  rst_req_if.sync rq
);

  genvar g;
  generate
    for (g = 0; g < NRST; g++) begin : g_dom
      logic stage1_q;
      logic stage2_q;
      logic out_q;
      // stage1 feeds only stage2; output asserts at once, releases after two more edges
      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          stage1_q <= 1'b1;
          stage2_q <= 1'b1;
          out_q <= 1'b1;
        end else if (i_clk_en) begin
          stage1_q <= rq.req[g];
          stage2_q <= stage1_q;
          out_q <= rq.req[g] | stage2_q;
        end
      end
      assign rq.rst[g] = out_q;
    end
  endgenerate

endmodule : rst_release_sync

// *** rtl/rst_req_if.sv ***
// carrier of internal reset requests and their released outputs
`timescale 1ns/1ps
interface rst_req_if;
  import rst_pkg::*;
  logic [NRST-1:0] req;
  logic [NRST-1:0] rst;
  modport src (output req, input rst);
  modport sync (input req, output rst);
endinterface : rst_req_if

// *** rtl/strap_capture.sv ***
// latch of the configuration strap pins at reset release
`timescale 1ns/1ps
module strap_capture
  import rst_pkg::*;
(
  // clock and control
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  // capture strobe and pins
  input wire logic i_capture,
  input wire logic [STRAP_W-1:0] i_pins,
  // latched defaults
  output logic [STRAP_W-1:0] o_value
);

  genvar g;
  generate
    for (g = 0; g < STRAP_W; g++) begin : g_bit
      logic val_q;
      // only the caller's strobe loads a pin value; i_rst loads the default, other resets never touch it
      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          val_q <= STRAP_RST[g];
        end else if (i_clk_en && i_capture) begin
          val_q <= i_pins[g];
        end
      end
      assign o_value[g] = val_q;
    end
  endgenerate

endmodule : strap_capture

// *** testbench/rst_ctl_asserts.sv ***
// concurrent checks of the reset sequencer at its top ports
`timescale 1ns/1ps
module rst_ctl_asserts
  import rst_pkg::*;
#(
  parameter int unsigned POR_CNT = POR_CYCLES
)(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  // watched inputs
  input wire logic i_external_reset_n,
  input wire logic i_test_reset_n,
  input wire logic i_usb_bus_reset,
  input wire logic i_out_data_ack,
  input wire logic i_eeprom_present,
  // watched outputs
  input wire logic o_usb_disconnect,
  input wire logic o_eeprom_full_load,
  input wire logic o_eeprom_mac_load,
  input wire logic o_core_rst,
  input wire logic o_usb_core_rst,
  input wire logic o_tap_rst,
  input wire logic o_pll_enable,
  input wire logic o_phy_power_down,
  input wire logic o_strap_oe_n,
  input wire logic [STRAP_W-1:0] o_strap_value
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // cycles since power-on release, saturating so it never wraps back into the window
  logic [CNT_W-1:0] since_q;
  always_ff @(posedge i_clock) begin
    if (i_rst) since_q <= '0;
    else if (i_clk_en && since_q != '1) since_q <= since_q + 1'b1;
  end
  // the last reset edge leaves the tap flop at its reset value, so it starts no attempt
  a_tap_follow: assert property (!i_rst && i_clk_en |=> o_tap_rst != $past(i_test_reset_n))
    else $error("tap reset does not follow test reset pin");
  a_por_hold: assert property (since_q < CNT_W'(POR_CNT) |-> o_core_rst && !o_pll_enable)
    else $error("core released before power-on timer ran out");
  a_por_load: assert property (i_eeprom_present && !i_usb_bus_reset &&
    since_q == CNT_W'(POR_CNT) |-> ##[10:40] o_eeprom_full_load)
    else $error("no full eeprom load after power-on");
  a_pin_quiet: assert property (!i_external_reset_n [*2] |=>
    o_strap_oe_n && !o_pll_enable && o_core_rst && o_phy_power_down)
    else $error("pin reset does not hold chip");
  a_soft_ack: assert property ($rose(o_usb_disconnect) && !$past(i_rst) &&
    i_external_reset_n && $past(i_external_reset_n) |->
    $past(i_out_data_ack) || $past(i_out_data_ack, 2) || $past(i_out_data_ack, 3))
    else $error("disconnect without acked OUT data");
  a_soft_pd: assert property ($rose(o_usb_disconnect) |-> ##[0:3] o_phy_power_down)
    else $error("phy not powered down in soft reset");
  a_lite_pll: assert property (o_core_rst && !o_usb_core_rst && i_external_reset_n &&
    $past(i_external_reset_n) |-> o_pll_enable)
    else $error("pll stopped in partial reset");
  a_strap_latch: assert property ($changed(o_strap_value) && !$past(i_rst) |->
    $past(o_strap_oe_n))
    else $error("straps relatched outside pin or power-on reset");
  a_usb_kept: assert property (i_usb_bus_reset && i_external_reset_n && !o_usb_core_rst
    |=> !o_usb_core_rst)
    else $error("usb core reset by usb bus reset");
  a_mac_load: assert property ($fell(i_usb_bus_reset) && i_eeprom_present &&
    !o_usb_core_rst && !$past(i_rst) |-> ##[1:20] (o_eeprom_mac_load && !o_eeprom_full_load))
    else $error("usb reset without mac only load");
endmodule : rst_ctl_asserts

bind chip_reset_and_strap_control rst_ctl_asserts #(.POR_CNT(POR_CNT)) u_asserts (
  .i_clock, .i_rst, .i_clk_en, .i_external_reset_n, .i_test_reset_n, .i_usb_bus_reset,
  .i_out_data_ack, .i_eeprom_present, .o_usb_disconnect, .o_eeprom_full_load,
  .o_eeprom_mac_load, .o_core_rst, .o_usb_core_rst, .o_tap_rst, .o_pll_enable,
  .o_phy_power_down, .o_strap_oe_n, .o_strap_value
);

// *** testbench/tb.sv ***
// self-checking bench of the chip reset sequencer
`timescale 1ns/1ps
module tb;
  import rst_pkg::*;
  localparam int unsigned POR_SIM = 20;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic i_clk_en = 1'b1;
  logic i_external_reset_n = 1'b1;
  logic i_test_reset_n = 1'b1;
  logic [ADDR_W-1:0] i_reg_addr = 8'h00;
  logic [DATA_W-1:0] i_reg_wdata = 32'h0;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic i_usb_bus_reset = 1'b0;
  logic i_eeprom_present = 1'b1;
  logic [STRAP_W-1:0] i_strap_pin = 4'hA;
  logic send = 1'b0;
  logic slow = 1'b1;
  logic i_out_data_ack, i_eeprom_done, o_usb_disconnect, o_eeprom_full_load, o_eeprom_mac_load;
  logic o_core_rst, o_usb_core_rst, o_tap_rst, o_pll_enable, o_phy_power_down, o_strap_oe_n;
  logic [DATA_W-1:0] o_reg_rdata;
  logic [STRAP_W-1:0] o_strap_pin, o_strap_value;
  int fails = 0;
  int n_tests = 0;
  int n_full = 0;
  int n_mac = 0;

  always #(CLOCK_NS / 2) i_clock = ~i_clock;

  chip_reset_and_strap_control #(.POR_CNT(POR_SIM)) uut (
    .i_clock, .i_rst, .i_clk_en, .i_external_reset_n, .i_test_reset_n, .i_reg_addr,
    .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_usb_bus_reset, .i_out_data_ack,
    .o_usb_disconnect, .i_eeprom_present, .i_eeprom_done, .o_eeprom_full_load,
    .o_eeprom_mac_load, .o_core_rst, .o_usb_core_rst, .o_tap_rst, .o_pll_enable,
    .o_phy_power_down, .i_strap_pin, .o_strap_pin, .o_strap_oe_n, .o_strap_value
  );
  usb_eeprom_model far (.i_clock, .i_slow(slow), .i_send(send), .i_full_load(o_eeprom_full_load),
    .i_mac_load(o_eeprom_mac_load), .i_disconnect(o_usb_disconnect), .o_done(i_eeprom_done),
    .o_ack(i_out_data_ack));

  // count load requests seen by the eeprom side
  always @(posedge i_clock) begin
    if (o_eeprom_full_load === 1'b1) n_full++;
    if (o_eeprom_mac_load === 1'b1) n_mac++;
  end

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %0h want %0h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clock);
    i_reg_wr <= 1'b0;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clock);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clock);
    i_reg_rd <= 1'b0;
    #1 d = o_reg_rdata;
  endtask : rd_reg

  // host polls ready before touching control registers; bounded
  task automatic wait_ready();
    logic [31:0] v;
    v = 32'h0;
    for (int i = 0; i < 300 && v[PMT_READY_BIT] !== 1'b1; i++) rd_reg(PMT_OFS, v);
    if (v[PMT_READY_BIT] !== 1'b1) begin
      fails++;
      end_of_test();
    end
  endtask : wait_ready

  // a bounded wait that ran out ends the run as a failure
  task automatic expire(input logic hung);
    if (hung !== 1'b0) begin
      fails++;
      end_of_test();
    end
  endtask : expire

  initial begin
    logic [31:0] v;
    time t0;
    repeat (10) @(posedge i_clock);
    i_rst <= 1'b0;
    // power-on: not ready, phy parked, one full load, straps latched
    rd_reg(PMT_OFS, v);
    chk(32'(v[1:0]), 32'h2, "por ready");
    wait_ready();
    slow = 1'b0;
    rd_reg(PMT_OFS, v);
    chk(v & 32'hF03, 32'hA03, "por pmt");
    chk(32'({4'(n_full), o_strap_value}), 32'h1A, "por load");
    $display("end power-on");
    // register fields, strap drive and an unmapped hole
    wr_reg(HW_CONFIG_OFS, 32'h0000ABFC);
    wr_reg(PMT_OFS, 32'h0);
    wr_reg(STRAP_OUT_OFS, 32'h5);
    rd_reg(HW_CONFIG_OFS, v);
    chk(v, 32'h0000ABFC, "hw_config_reg");
    rd_reg(PMT_OFS, v);
    chk(v & 32'hF03, 32'hA01, "pmt write");
    rd_reg(8'h0C, v);
    chk(v, 32'h0, "hole");
    chk(32'({o_strap_oe_n, o_strap_pin}), 32'h5, "strap drive");
    $display("end registers");
    // soft reset as if the pin were unused; moved straps must not relatch
    @(posedge i_clock);
    i_strap_pin <= 4'h3;
    wr_reg(HW_CONFIG_OFS, 32'h0000ABFD);
    rd_reg(HW_CONFIG_OFS, v);
    chk(32'({o_usb_disconnect, v[0]}), 32'h1, "soft pending");
    @(posedge i_clock);
    send <= 1'b1;
    @(posedge i_clock);
    send <= 1'b0;
    t0 = $time;
    for (int i = 0; i < 200 && v[0] !== 1'b0; i++) rd_reg(HW_CONFIG_OFS, v);
    expire(v[0]);
    chk(32'(($time - t0) >= SOFT_TIME_NS), 32'h1, "soft length");
    wait_ready();
    rd_reg(HW_CONFIG_OFS, v);
    chk(v, 32'h0000AB00, "soft keeps");
    rd_reg(PMT_OFS, v);
    chk(v & 32'hF03, 32'hA03, "soft pmt");
    chk(32'(n_full), 32'h2, "soft load");
    $display("end soft reset");
    // usb bus reset: not ready meanwhile, mac only reload
    wr_reg(PMT_OFS, 32'h0);
    @(posedge i_clock);
    i_usb_bus_reset <= 1'b1;
    rd_reg(PMT_OFS, v);
    chk(32'(v[0]), 32'h0, "bus ready");
    repeat (20) @(posedge i_clock);
    i_usb_bus_reset <= 1'b0;
    wait_ready();
    rd_reg(PMT_OFS, v);
    chk(32'({v[1], 4'(n_mac), 4'(n_full)}), 32'h112, "bus load");
    $display("end usb reset");
    // lite reset: core only, pll on, ready kept, no load
    wr_reg(HW_CONFIG_OFS, 32'h0000AB02);
    @(posedge i_clock);
    #1 chk(32'({o_core_rst, o_usb_core_rst, o_pll_enable}), 32'h5, "lite");
    rd_reg(PMT_OFS, v);
    chk(32'({v[0], 4'(n_mac), 4'(n_full)}), 32'h112, "lite load");
    // host would reset its bulk and interrupt pipes here
    for (int i = 0; i < 50 && o_core_rst !== 1'b0; i++) @(posedge i_clock);
    expire(o_core_rst);
    rd_reg(HW_CONFIG_OFS, v);
    chk(32'({o_core_rst, v[15:0]}), 32'hAB00, "lite end");
    $display("end lite reset");
    // pin reset: chip held, straps floated and relatched, full load
    @(posedge i_clock);
    i_strap_pin <= 4'h6;
    i_external_reset_n <= 1'b0;
    rd_reg(PMT_OFS, v);
    chk(32'({v[0], o_strap_oe_n, o_pll_enable}), 32'h2, "pin held");
    rd_reg(HW_CONFIG_OFS, v);
    chk(v, 32'h0, "pin hw_config_reg");
    @(posedge i_clock);
    i_external_reset_n <= 1'b1;
    wait_ready();
    rd_reg(PMT_OFS, v);
    chk(v & 32'hF03, 32'h603, "pin pmt");
    chk(32'({o_strap_oe_n, 4'(n_full)}), 32'h3, "pin load");
    $display("end pin reset");
    // test reset touches the tap only; a low clock enable holds it back
    @(posedge i_clock);
    i_clk_en <= 1'b0;
    i_test_reset_n <= 1'b0;
    repeat (2) @(posedge i_clock);
    #1 chk(32'(o_tap_rst), 32'h0, "frozen");
    @(posedge i_clock);
    i_clk_en <= 1'b1;
    repeat (2) @(posedge i_clock);
    #1 chk(32'({o_tap_rst, o_core_rst}), 32'h2, "tap");
    $display("end test reset");
    end_of_test();
  end
endmodule : tb

// *** testbench/usb_eeprom_model.sv ***
// far side model: usb host sending OUT data and the eeprom loader
`timescale 1ns/1ps
module usb_eeprom_model (
  // clock and bench controls
  input wire logic i_clock,
  input wire logic i_slow,
  input wire logic i_send,
  // from the sequencer
  input wire logic i_full_load,
  input wire logic i_mac_load,
  input wire logic i_disconnect,
  // answers
  output logic o_done,
  output logic o_ack
);
  // answers settle at the first edge, while the sequencer is still held in reset
  int wait_q = 0;
  // loader answers fast or slow; a detached device never acks OUT data
  always @(posedge i_clock) begin
    o_done <= (wait_q == 1);
    o_ack <= i_send && !i_disconnect;
    if (i_full_load || i_mac_load) begin
      wait_q <= i_slow ? 40 : 3;
    end else if (wait_q > 0) begin
      wait_q <= wait_q - 1;
    end
  end
endmodule : usb_eeprom_model
